// ### bench/aps_link_checker.sv
// Purpose: assertions on the host-to-converter link and power outputs
// Assumes: one clock, async active-low reset
// Notes:   power bits tracked here from control writes
`timescale 1ns/100ps
module aps_link_checker
	import aps_pkg::*;
#(
	parameter int CAL_TOTAL = 50,
	parameter int CONV_LEN  = 325
)(
	input wire logic       clk_sys,
	input wire logic       rst_n,
	input wire logic       convertStart,
	input wire logic       sleepN,
	input wire logic       ctrlWrite,
	input wire logic [1:0] ctrlPowerMode,
	input wire logic       busy,
	input wire logic       calActive,
	input wire logic       coreOn,
	input wire logic       refOn
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic [1:0] pm;
	logic       started;
	logic       cancelled;
	logic [9:0] busyCnt;
	logic [9:0] calCnt;
	logic [9:0] upCnt;
	logic       between;
	assign between = (pm == 2'h1) || (pm == 2'h3) || (pm == 2'h0 && !sleepN);
	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pm <= 2'h0;
			started <= 1'b0;
			cancelled <= 1'b0;
			busyCnt <= 10'h0;
			calCnt <= 10'h0;
			upCnt <= 10'h0;
		end
		else
		begin
			pm <= ctrlWrite ? ctrlPowerMode : pm;
			started <= started | !convertStart;
			cancelled <= cancelled | (ctrlWrite & !started);
			busyCnt <= busy ? busyCnt + 10'h1 : 10'h0;
			calCnt <= calActive ? calCnt + 10'h1 : 10'h0;
			// saturates: always-on mode may stay up far longer
			upCnt <= !coreOn ? 10'h0 : ((upCnt == 10'h3FF) ? upCnt : upCnt + 10'h1);
		end
	end
	////////////////////////////////////////////////////////////////////////////
	sequence s_awake;
		(pm == 2'h0 && sleepN && !busy && !calActive) [*8];
	endsequence
	sequence s_wake_req;
		$fell(convertStart) && !coreOn && pm != 2'h2;
	endsequence
	a_busy_length: assert property ($fell(busy) |-> int'(busyCnt) == CONV_LEN)
		else $error("conversion length wrong");
	a_sleep_at_end: assert property ($fell(busy) && between |-> ##[0:3] !coreOn)
		else $error("no power-down after conversion");
	a_part_ref: assert property (pm == 2'h3 |-> ##[0:4] refOn)
		else $error("reference off in partial mode");
	a_off_all: assert property (pm == 2'h2 && !calActive |-> ##[0:4] (!coreOn && !refOn && !busy))
		else $error("circuits alive in full power-down");
	a_wake_fall: assert property (s_wake_req |-> ##[1:6] coreOn)
		else $error("no wake on convert start fall");
	a_wake_time: assert property ($rose(busy) |-> int'(upCnt) >= WAKE_CYC)
		else $error("conversion before wake completed");
	a_cal_power: assert property (calActive |-> coreOn)
		else $error("powered down during calibration");
	a_cal_length: assert property ($fell(calActive) |-> int'(calCnt) == CAL_TOTAL)
		else $error("power-up sequence length wrong");
	a_cal_start: assert property ($fell(convertStart) && !started && !cancelled |-> ##[1:6] calActive)
		else $error("first convert start did not calibrate");
	a_cancel_cal: assert property (cancelled |-> !calActive)
		else $error("calibration ran after cancel");
	a_full_up: assert property (s_awake |-> ##[0:8] coreOn)
		else $error("core off in full power-up");
endmodule : aps_link_checker

// ### bench/tb_adc_power_mode_sequencer.sv
// Purpose: self-checking bench for host and converter power sequencer
// Assumes: both ends joined by the link interface, software on APB
// Notes:   power-up counts shortened to keep the run short
`timescale 1ns/100ps
module tb_adc_power_mode_sequencer import aps_pkg::*;;
	localparam int TO_CYC  = 20;
	localparam int CAL_LEN = 30;
	logic        clk_sys = 1'b0;
	logic        rst_n   = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        coreOn;
	logic        refOn;
	logic        convDone;
	logic [31:0] rd;
	logic        err;
	int          fails = 0;
	int          check_count = 0;
	int          n;
	logic [31:0] tCtrl [6] = '{32'h0, 32'h7, 32'h5, 32'h4, 32'h4, 32'h1};
	logic [31:0] tCmd  [6] = '{32'h1, 32'h1, 32'h2, 32'h2, 32'h1, 32'h1};
	int          tHi   [6] = '{1000, 1000, 1000, 8, 1000, 1000};
	logic [1:0]  tPwr  [6] = '{2'h0, 2'h1, 2'h0, 2'h3, 2'h3, 2'h0};
	aps_link_if lnk ();
	aps_device #(.TIMEOUT_CYC(TO_CYC), .CAL_CYC(CAL_LEN)) u_aps_device (.clk_sys(clk_sys),
		.rst_n(rst_n), .link(lnk.dev), .coreOn(coreOn), .refOn(refOn), .calibrating(),
		.converting(), .convDone(convDone));
	aps_host #(.HOLDOFF_LEN(50)) u_aps_host (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(lnk.host));
	aps_link_checker #(.CAL_TOTAL(TO_CYC + CAL_LEN), .CONV_LEN(CONV_CYC)) u_aps_link_checker (
		.clk_sys(clk_sys), .rst_n(rst_n), .convertStart(lnk.convertStart), .sleepN(lnk.sleepN),
		.ctrlWrite(lnk.ctrlWrite), .ctrlPowerMode(lnk.ctrlPowerMode), .busy(lnk.busy),
		.calActive(lnk.calActive), .coreOn(coreOn), .refOn(refOn));
	always #5 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		for (int i = 0; i < 20 && pready !== 1'b1; i++)
			@(posedge clk_sys);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb
	// wake must take the full recovery time, so the lower bound of 495 applies only when hi is above 8
	task automatic conv(input logic [31:0] cmd, input int hi, input logic [1:0] pwr);
		int w;
		int len;
		apb(1'b1, REG_CMD, cmd);
		for (w = 0; w < 2000 && lnk.busy !== 1'b1; w++)
			@(posedge clk_sys);
		check(32'(w >= ((hi > 8) ? 495 : 0) && w <= hi), 32'h1);
		for (len = 0; len < 2000 && lnk.busy === 1'b1; len++)
			@(posedge clk_sys);
		check(32'(len), 32'(CONV_CYC));
		// done pulse stands in the first cycle with busy low
		check({31'h0, convDone}, 32'h1);
		repeat (4) @(posedge clk_sys);
		check({30'h0, coreOn, refOn}, {30'h0, pwr});
	endtask : conv
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		apb(1'b0, REG_CTRL, 32'h0);
		check(rd, 32'(CTRL_RESET));
		apb(1'b0, 8'h0C, 32'h0);
		check({err, rd[30:0]}, 32'h80000000);
		apb(1'b1, REG_CMD, 32'h1);
		for (n = 0; n < 20 && lnk.calActive !== 1'b1; n++)
			@(posedge clk_sys);
		check(32'(lnk.calActive), 32'h1);
		apb(1'b1, REG_CTRL, 32'h0);
		check(32'(coreOn), 32'h1);
		repeat (1200) @(posedge clk_sys);
		$display("power-up sequence done");
		for (int t = 0; t < 6; t++)
		begin
			apb(1'b1, REG_CTRL, tCtrl[t]);
			repeat (600) @(posedge clk_sys);
			conv(tCmd[t], tHi[t], tPwr[t]);
		end
		$display("mode table done");
		apb(1'b1, REG_CTRL, 32'h6);
		apb(1'b1, REG_CMD, 32'h1);
		n = 0;
		repeat (700)
		begin
			@(posedge clk_sys);
			n += (lnk.busy !== 1'b0);
		end
		check(32'(n), 32'h0);
		check({30'h0, coreOn, refOn}, 32'h0);
		apb(1'b1, REG_CTRL, 32'h4);
		for (n = 0; n < 1000 && coreOn !== 1'b1; n++)
			@(posedge clk_sys);
		check(32'(n <= WAKE_CYC), 32'h1);
		$display("full power-down done");
		rst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		apb(1'b1, REG_CTRL, 32'h5);
		conv(32'h1, 1000, 2'h0);
		apb(1'b0, REG_STATUS, 32'h0);
		check(32'(rd[STAT_CAL]), 32'h0);
		$display("cancelled power-up done");
		report_and_stop();
	end
	// about 11000 cycles expected; allow well over twice that
	initial
	begin
		#300000;
		fails++;
		report_and_stop();
	end
endmodule : tb_adc_power_mode_sequencer

// ### inc/aps_link_if.sv
// Purpose: pins and control-register port between host and converter
// Assumes: both ends on clk_sys
// Notes:   no two-way pins
`timescale 1ns/100ps
interface aps_link_if;
	logic       convertStart;
	logic       sleepN;
	logic       ctrlWrite;
	logic [1:0] ctrlPowerMode;
	logic       ctrlStartConv;
	logic       ctrlStartCal;
	logic       busy;
	logic       calActive;

	modport dev (
		input  convertStart, sleepN, ctrlWrite, ctrlPowerMode, ctrlStartConv, ctrlStartCal,
		output busy, calActive
	);
	modport host (
		output convertStart, sleepN, ctrlWrite, ctrlPowerMode, ctrlStartConv, ctrlStartCal,
		input  busy, calActive
	);
endinterface : aps_link_if

// ### inc/aps_pkg.sv
// Purpose: shared constants and types of the converter power-mode sequencer
// Assumes: one 100 MHz clock on both ends
// Notes:   timing figures kept in their own units, cycle counts derived
package aps_pkg;

	localparam int CLK_MHZ      = 100;
	localparam int PWRUP_SEQ_MS = 35;
	localparam int PWRUP_SEQ_CYC = PWRUP_SEQ_MS * 1000 * CLK_MHZ;
	localparam int WAKE_US      = 5;
	localparam int WAKE_CYC     = WAKE_US * CLK_MHZ;
	localparam int CONV_NS      = 3250;
	localparam int CONV_CYC     = (CONV_NS * CLK_MHZ) / 1000;
	localparam int HOLDOFF_US   = 300;
	localparam int HOLDOFF_CYC  = HOLDOFF_US * CLK_MHZ;
	localparam int CNT_W        = 22;

	// power-mode bit codes
	localparam logic [1:0] PMB_PIN          = 2'h0;
	localparam logic [1:0] PMB_FULL_BETWEEN = 2'h1;
	localparam logic [1:0] PMB_OFF          = 2'h2;
	localparam logic [1:0] PMB_PART_BETWEEN = 2'h3;
	localparam logic [1:0] PMB_RESET        = 2'h0;

	// host register map, byte addresses
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_CMD    = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam int CTRL_PM_LO     = 0;
	localparam int CTRL_SLEEP     = 2;
	localparam int CMD_PIN_CONV   = 0;
	localparam int CMD_SW_CONV    = 1;
	localparam int CMD_SELF_CAL   = 2;
	localparam int STAT_BUSY      = 0;
	localparam int STAT_CAL       = 1;
	localparam int STAT_HOLDOFF   = 2;
	localparam int STAT_PULSE     = 3;
	localparam int STAT_CALPEND   = 4;
	localparam logic [2:0] CTRL_RESET = 3'h4;

	typedef enum logic [1:0] {
		MODE_ON           = 2'b00,
		MODE_OFF          = 2'b01,
		MODE_FULL_BETWEEN = 2'b10,
		MODE_PART_BETWEEN = 2'b11
	} aps_mode_type;

	function automatic aps_mode_type aps_decode_mode(input logic [1:0] pm, input logic sleepN);
		aps_mode_type m;
		m = MODE_ON;
		unique case (pm)
			PMB_PIN:          m = sleepN ? MODE_ON : MODE_FULL_BETWEEN;
			PMB_FULL_BETWEEN: m = MODE_FULL_BETWEEN;
			PMB_OFF:          m = MODE_OFF;
			PMB_PART_BETWEEN: m = MODE_PART_BETWEEN;
		endcase
		return m;
	endfunction : aps_decode_mode

endpackage : aps_pkg

// ### logic/aps_device.sv
// Purpose: converter-side power-mode sequencer
// Assumes: convert start and sleep are pins (synchronised); control writes
//          arrive as a same-clock strobe
// Notes:   analog power switches are modelled by coreOn and refOn
//
// Overview of operation
// RULE1: mode from power bits plus sleep pin
// RULE2: full off kills all; partial keeps reference
// RULE3: power bits reset to zero
// RULE4: decode table; sleep ignored unless bits 00
// RULE5: software-only host holds sleep high
// RULE6: host holds sleep low below 100 kSPS
// RULE7: first convert start: time-out then calibration
// RULE8: sleep ignored during power-up sequence
// RULE9: early control write cancels power-up sequence
// RULE10: host waits 300 us before self-calibration
// RULE11: recovery from power-down takes 5 us
// RULE12: between modes: power down when busy falls
// RULE13: convert start falling edge wakes device
// RULE14: host holds convert start low 5 us
// RULE15: software conversion powers up first
// RULE16: after power-up sequence apply decoded mode
`timescale 1ns/100ps
module aps_device
	import aps_pkg::*;
#(
	parameter int TIMEOUT_CYC = PWRUP_SEQ_CYC / 2,
	parameter int CAL_CYC     = PWRUP_SEQ_CYC - PWRUP_SEQ_CYC / 2,
	parameter int CONV_LEN    = CONV_CYC
)(
	input  wire logic clk_sys,
	input  wire logic rst_n,
	aps_link_if.dev   link,
	output logic      coreOn,
	output logic      refOn,
	output logic      calibrating,
	output logic      converting,
	output logic      convDone
);

	////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		ST_FIRST   = 3'h0,
		ST_TIMEOUT = 3'h1,
		ST_CALIB   = 3'h2,
		ST_IDLE    = 3'h3,
		ST_WAKE    = 3'h4,
		ST_CONVERT = 3'h5,
		ST_SLEEP   = 3'h6,
		ST_OFF     = 3'h7
	} aps_dstate_type;

	typedef struct packed {
		aps_dstate_type   state;
		logic [CNT_W-1:0] cnt;
		logic [1:0]       pmode;
		logic             pend;
		logic             cvS1;
		logic             cvS2;
		logic             cvPrev;
		logic             slS1;
		logic             slS2;
		logic             busy;
		logic             calActive;
		logic             coreOn;
		logic             refOn;
		logic             convDone;
	} aps_dev_type;

	localparam aps_dev_type DEV_RESET = '{
		state: ST_FIRST, cnt: '0, pmode: PMB_RESET, pend: 1'b0,
		cvS1: 1'b1, cvS2: 1'b1, cvPrev: 1'b1, slS1: 1'b1, slS2: 1'b1,
		busy: 1'b0, calActive: 1'b0, coreOn: 1'b1, refOn: 1'b1, convDone: 1'b0
	};

	aps_dev_type r;
	aps_dev_type next_r;

	// state to settle into for a decoded mode, outside any conversion
	function automatic aps_dstate_type aps_settle(input aps_mode_type m);
		aps_dstate_type s;
		s = ST_IDLE;
		unique case (m)
			MODE_ON:           s = ST_IDLE;
			MODE_OFF:          s = ST_OFF;
			MODE_FULL_BETWEEN: s = ST_SLEEP;
			MODE_PART_BETWEEN: s = ST_SLEEP;
		endcase
		return s;
	endfunction : aps_settle

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		aps_mode_type mode;
		aps_mode_type wrMode;
		logic cvFall;
		logic cvRise;
		logic cntDone;
		logic swConv;
		logic swCal;
		next_r = r;
		mode = aps_decode_mode(r.pmode, r.slS2);                       // [RULE1] [RULE4]
		wrMode = aps_decode_mode(link.ctrlPowerMode, r.slS2);
		cvFall = r.cvPrev & ~r.cvS2;
		cvRise = ~r.cvPrev & r.cvS2;
		cntDone = (r.cnt == '0);
		swConv = link.ctrlWrite & link.ctrlStartConv;
		swCal = link.ctrlWrite & link.ctrlStartCal;
		next_r.cvS1 = link.convertStart;
		next_r.cvS2 = r.cvS1;
		next_r.cvPrev = r.cvS2;
		next_r.slS1 = link.sleepN;
		next_r.slS2 = r.slS1;
		next_r.convDone = 1'b0;
		if (!cntDone)
			next_r.cnt = r.cnt - 1'b1;
		if (link.ctrlWrite)
			next_r.pmode = link.ctrlPowerMode;

		unique case (r.state)
			ST_FIRST:
			begin
				if (link.ctrlWrite)
					next_r.state = aps_settle(wrMode);                 // [RULE9] [RULE16]
				else if (cvFall)
				begin
					next_r.state = ST_TIMEOUT;                         // [RULE7]
					next_r.cnt = CNT_W'(TIMEOUT_CYC - 1);
				end
			end
			// sleep pin deliberately not looked at here
			ST_TIMEOUT:
			begin
				if (cntDone)
				begin
					next_r.state = ST_CALIB;                           // [RULE7] [RULE8]
					next_r.cnt = CNT_W'(CAL_CYC - 1);
				end
			end
			ST_CALIB:
			begin
				if (cntDone)
					next_r.state = aps_settle(mode);                   // [RULE16] [RULE8]
			end
			ST_IDLE:
			begin
				if (swCal)
				begin
					next_r.state = ST_CALIB;
					next_r.cnt = CNT_W'(CAL_CYC - 1);
				end
				else if (swConv || cvRise)
				begin
					next_r.state = ST_CONVERT;
					next_r.cnt = CNT_W'(CONV_LEN - 1);
				end
				else if (mode == MODE_OFF)
					next_r.state = ST_OFF;
			end
			ST_WAKE:
			begin
				if (swConv || cvRise)
					next_r.pend = 1'b1;
				if (cntDone)
				begin
					next_r.pend = 1'b0;
					if (r.pend || swConv || cvRise)
					begin
						next_r.state = ST_CONVERT;                     // [RULE15]
						next_r.cnt = CNT_W'(CONV_LEN - 1);
					end
					else
						next_r.state = ST_IDLE;                        // [RULE11] [RULE13]
				end
			end
			ST_CONVERT:
			begin
				if (cntDone)
				begin
					next_r.convDone = 1'b1;
					next_r.state = (mode == MODE_ON) ? ST_IDLE : aps_settle(mode); // [RULE12]
				end
			end
			ST_SLEEP:
			begin
				if (mode == MODE_OFF)
					next_r.state = ST_OFF;
				else if (cvFall || swConv || mode == MODE_ON)
				begin
					next_r.state = ST_WAKE;                            // [RULE13] [RULE15]
					next_r.pend = swConv;
					next_r.cnt = CNT_W'(WAKE_CYC - 1);
				end
			end
			ST_OFF:
			begin
				if (mode == MODE_ON)
				begin
					next_r.state = ST_WAKE;                            // [RULE11]
					next_r.pend = 1'b0;
					next_r.cnt = CNT_W'(WAKE_CYC - 1);
				end
				else if (mode != MODE_OFF)
					next_r.state = ST_SLEEP;
			end
		endcase

		// power switches follow the next state so outputs stay registered
		next_r.coreOn = (next_r.state != ST_SLEEP) && (next_r.state != ST_OFF);   // [RULE2]
		next_r.refOn = next_r.coreOn ||
			(next_r.state == ST_SLEEP && mode == MODE_PART_BETWEEN);             // [RULE2]
		next_r.busy = (next_r.state == ST_CONVERT);
		next_r.calActive = (next_r.state == ST_TIMEOUT) || (next_r.state == ST_CALIB);
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			r <= DEV_RESET;                                            // [RULE3]
		else
			r <= next_r;
	end

	////////////////////////////////////////////////////////////////////////
	assign link.busy      = r.busy;
	assign link.calActive = r.calActive;
	assign coreOn         = r.coreOn;
	assign refOn          = r.refOn;
	assign calibrating    = r.calActive;
	assign converting     = r.busy;
	assign convDone       = r.convDone;

endmodule : aps_device

// ### logic/aps_host.sv
// Purpose: host controller driving convert start, sleep and control writes
// Assumes: APB slave towards software, one wait state per access
// Notes:   busy and calibration status pass a two-flop synchroniser
`timescale 1ns/100ps
module aps_host
	import aps_pkg::*;
#(
	parameter int HOLDOFF_LEN = HOLDOFF_CYC,
	parameter int PULSE_LEN   = WAKE_CYC
)(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	aps_link_if.host         link
);

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [2:0]       ctrl;
		logic             firstDone;
		logic [CNT_W-1:0] holdoff;
		logic [CNT_W-1:0] pulseCnt;
		logic             pulsing;
		logic             calPend;
		logic             bS1;
		logic             bS2;
		logic             cS1;
		logic             cS2;
		logic             convertStart;
		logic             ctrlWrite;
		logic [1:0]       wrMode;
		logic             wrConv;
		logic             wrCal;
		logic [31:0]      prdata;
		logic             pready;
		logic             pslverr;
	} aps_host_type;

	localparam aps_host_type HOST_RESET = '{
		ctrl: CTRL_RESET, firstDone: 1'b0, holdoff: '0, pulseCnt: '0,
		pulsing: 1'b0, calPend: 1'b0, bS1: 1'b0, bS2: 1'b0, cS1: 1'b0,
		cS2: 1'b0, convertStart: 1'b1, ctrlWrite: 1'b0, wrMode: PMB_RESET,
		wrConv: 1'b0, wrCal: 1'b0, prdata: '0, pready: 1'b0, pslverr: 1'b0
	};

	aps_host_type r;
	aps_host_type next_r;

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		logic acc;
		logic wr;
		logic mapped;
		next_r = r;
		acc = psel & penable & ~r.pready;
		wr = psel & penable & pwrite & r.pready;
		mapped = (paddr == REG_CTRL) || (paddr == REG_CMD) || (paddr == REG_STATUS);
		next_r.bS1 = link.busy;
		next_r.bS2 = r.bS1;
		next_r.cS1 = link.calActive;
		next_r.cS2 = r.cS1;
		next_r.ctrlWrite = 1'b0;
		next_r.wrConv = 1'b0;
		next_r.wrCal = 1'b0;
		next_r.pready = acc;
		next_r.pslverr = acc & ~mapped;
		next_r.prdata = '0;
		if (acc && !pwrite && paddr == REG_CTRL)
			next_r.prdata = {29'h0, r.ctrl};
		else if (acc && !pwrite && paddr == REG_STATUS)
			next_r.prdata = {27'h0, r.calPend, r.pulsing, (r.holdoff != '0), r.cS2, r.bS2};

		if (r.holdoff != '0)
			next_r.holdoff = r.holdoff - 1'b1;

		// convert-start low pulse, long enough to cover wake-up
		if (r.pulsing)
		begin
			if (r.pulseCnt == '0)
			begin
				next_r.convertStart = 1'b1;
				next_r.pulsing = 1'b0;
			end
			else
				next_r.pulseCnt = r.pulseCnt - 1'b1;                  // [RULE14]
		end

		if (wr && paddr == REG_CTRL)
		begin
			next_r.ctrl = pwdata[2:0];
			next_r.ctrlWrite = 1'b1;
			next_r.wrMode = pwdata[CTRL_PM_LO +: 2];
			next_r.firstDone = 1'b1;
			if (!r.firstDone)
				next_r.holdoff = CNT_W'(HOLDOFF_LEN);                  // [RULE9] [RULE10]
		end
		else if (wr && paddr == REG_CMD)
		begin
			if (pwdata[CMD_PIN_CONV] && !r.pulsing)
			begin
				next_r.convertStart = 1'b0;
				next_r.pulsing = 1'b1;
				next_r.pulseCnt = CNT_W'(PULSE_LEN);
				next_r.firstDone = 1'b1;
			end
			if (pwdata[CMD_SW_CONV])
			begin
				next_r.ctrlWrite = 1'b1;                               // [RULE15]
				next_r.wrMode = r.ctrl[CTRL_PM_LO +: 2];
				next_r.wrConv = 1'b1;
				next_r.firstDone = 1'b1;
			end
			if (pwdata[CMD_SELF_CAL])
				next_r.calPend = 1'b1;
		end
		// self-calibration waits out the hold-off after a cancelled power-up
		else if (r.calPend && r.holdoff == '0 && !r.ctrlWrite)
		begin
			next_r.calPend = 1'b0;                                     // [RULE10]
			next_r.ctrlWrite = 1'b1;
			next_r.wrMode = r.ctrl[CTRL_PM_LO +: 2];
			next_r.wrCal = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			r <= HOST_RESET;
		else
			r <= next_r;
	end

	////////////////////////////////////////////////////////////////////////
	assign prdata             = r.prdata;
	assign pready             = r.pready;
	assign pslverr            = r.pslverr;
	assign link.convertStart  = r.convertStart;
	assign link.sleepN        = r.ctrl[CTRL_SLEEP];                   // [RULE5] [RULE6]
	assign link.ctrlWrite     = r.ctrlWrite;
	assign link.ctrlPowerMode = r.wrMode;
	assign link.ctrlStartConv = r.wrConv;
	assign link.ctrlStartCal  = r.wrCal;

endmodule : aps_host
